// file: ddc_decim_format.sv
// Functional notes
// - Decimate 2 uses 55-tap; 4 uses 19 then 55, or 63 when wide select set.
// - Decimate 16 cascades the 7, 11, 15 and 55 tap stages.
// - Stages decimate by two with the fixed integer half-band coefficient sets.
// - Each coefficient set is mirrored about its single center tap.
// - Mode 9 gives decimate-by-2 real samples with 15 data bits.
// - Complex modes 10 to 16 except 12 carry 15-bit data plus both flags.
// - Mode 12 gives 12-bit complex data; flags go to four dedicated pins.
// - Real words: data in bits 15..1, bit 0 first flag even, second odd.
// - Complex words: I carries first flag in bit 0, Q carries second.
// - Mode selector alone picks decimation; bypass passes real samples undecimated.
// - Modes 10-12 decimate 4, 13-14 decimate 8, 15-16 decimate 16, complex.
// - Gain boost set gives 6.02 dB chain gain, clear gives 0 dB.
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/1ps

module halfband_stage #(
    parameter int SET = 0,
    parameter int OW  = 16
) (
    input  wire logic           clk_sys,
    input  wire logic           nrst,
    input  wire logic           clr,
    input  wire logic           boost,
    input  wire logic           in_v,
    input  wire ddc_pkg::samp_t in_s,
    output logic                out_v,
    output ddc_pkg::samp_t      out_s
);

    localparam int N  = ddc_pkg::NTAP_TBL[SET];
    localparam int SH = ddc_pkg::SHIFT_TBL[SET];
    localparam logic signed [47:0] MAXV = (48'sh1 <<< (OW - 1)) - 48'sh1;
    localparam logic signed [47:0] MINV = -MAXV - 48'sh1;

    logic signed [15:0] tap_i_r [N];
    logic signed [15:0] tap_q_r [N];
    logic               phase_r;
    logic               pend_r;
    logic               out_v_r;
    ddc_pkg::samp_t     out_r;
    logic signed [47:0] acc_i;
    logic signed [47:0] acc_q;

    // Unity DC gain divides by twice the center tap; a 15-bit stage drops one more bit
    // So full scale in stays full scale out without boost, and boost gives that bit back
    function automatic logic signed [15:0] scale_sat(input logic signed [47:0] acc, input logic bst);
        logic signed [47:0] v;
        v = bst ? (acc >>> (SH + 16 - OW)) : (acc >>> (SH + 17 - OW));
        if (v > MAXV) begin
            v = MAXV;
        end else if (v < MINV) begin
            v = MINV;
        end
        return v[15:0];
    endfunction

    // ------------------------------------------------------------------
    // Delay line, advanced on every input sample
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!nrst || clr) begin
            phase_r <= 1'b0;
            pend_r  <= 1'b0;
            for (int k = 0; k < N; k++) begin
                tap_i_r[k] <= '0;
                tap_q_r[k] <= '0;
            end
        end else begin
            pend_r <= in_v & phase_r;
            if (in_v) begin
                phase_r    <= ~phase_r;
                tap_i_r[0] <= in_s.i;
                tap_q_r[0] <= in_s.q;
                for (int k = 1; k < N; k++) begin
                    tap_i_r[k] <= tap_i_r[k - 1];
                    tap_q_r[k] <= tap_q_r[k - 1];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Full-width convolution; computed every cycle, registered only on every second sample
    // ------------------------------------------------------------------
    always_comb begin
        acc_i = '0;
        acc_q = '0;
        for (int k = 0; k < N; k++) begin
            acc_i = acc_i + 48'(tap_i_r[k]) * 48'(ddc_pkg::coef(SET, k));
            acc_q = acc_q + 48'(tap_q_r[k]) * 48'(ddc_pkg::coef(SET, k));
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst || clr) begin
            out_v_r <= 1'b0;
            out_r   <= '0;
        end else begin
            out_v_r <= pend_r;
            if (pend_r) begin
                out_r.i <= scale_sat(acc_i, boost);
                out_r.q <= scale_sat(acc_q, boost);
            end
        end
    end

    assign out_v = out_v_r;
    assign out_s = out_r;

    stage_strobe_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (out_v_r && !$past(clr)) |-> ($past(in_v, 2) && $past(phase_r, 2)))
        else $error("Stage output without a second input sample");

endmodule

module ddc_decim_format (
    input  wire logic           clk_sys,
    input  wire logic           nrst,
    input  wire logic [1:0]     bus_addr,
    input  wire logic [15:0]    bus_wdata,
    input  wire logic           bus_wr,
    input  wire logic           bus_rd,
    output logic      [15:0]    bus_rdata,
    input  wire logic           in_valid,
    input  wire ddc_pkg::samp_t chan_in [2],
    input  wire logic [1:0]     ovr_in  [2],
    output logic                out_valid,
    output logic      [15:0]    word_i  [2],
    output logic      [15:0]    word_q  [2],
    output logic                chan_a_overrange_pin_first,
    output logic                chan_a_overrange_pin_second,
    output logic                chan_b_overrange_pin_first,
    output logic                chan_b_overrange_pin_second
);

    logic [4:0]  link_mode_select_r;
    logic        quarter_rate_wide_passband_sel_r;
    logic        boost_r;
    logic        flush_r;
    logic [15:0] rdata_r;
    logic [15:0] count_r;
    logic        out_valid_r;
    logic        byp;
    logic        d2;
    logic        d4;
    logic        d8;
    logic        d16;
    logic        no_flags;
    logic        emit [2];
    logic [1:0]  pin_r [2];
    logic [15:0] word_i_r [2];
    logic [15:0] word_q_r [2];

    // ------------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------------
    // Any change of routing flushes the chain so stale half-sums never leak out
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            link_mode_select_r               <= ddc_pkg::MODE_RST;
            quarter_rate_wide_passband_sel_r <= ddc_pkg::WIDE_RST;
            boost_r                          <= ddc_pkg::BOOST_RST;
            flush_r                          <= 1'b0;
        end else begin
            flush_r <= 1'b0;
            if (bus_wr) begin
                case (bus_addr)
                    ddc_pkg::REG_MODE: begin
                        link_mode_select_r <= bus_wdata[4:0];
                        flush_r            <= 1'b1;
                    end
                    ddc_pkg::REG_CFG: begin
                        quarter_rate_wide_passband_sel_r <= bus_wdata[ddc_pkg::CFG_WIDE_BIT];
                        boost_r                          <= bus_wdata[ddc_pkg::CFG_BOOST_BIT];
                        flush_r                          <= 1'b1;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= '0;
            if (bus_rd) begin
                case (bus_addr)
                    ddc_pkg::REG_MODE:  rdata_r <= {11'h000, link_mode_select_r};
                    ddc_pkg::REG_CFG:   rdata_r <= {14'h0000, boost_r, quarter_rate_wide_passband_sel_r};
                    ddc_pkg::REG_COUNT: rdata_r <= count_r;
                    default:            rdata_r <= '0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------
    always_comb begin
        d2       = (link_mode_select_r == ddc_pkg::MODE_D2);
        d4       = (link_mode_select_r >= ddc_pkg::MODE_D4_FIRST) &&
                   (link_mode_select_r < ddc_pkg::MODE_D8_FIRST);
        d8       = (link_mode_select_r >= ddc_pkg::MODE_D8_FIRST) &&
                   (link_mode_select_r < ddc_pkg::MODE_D16_FIRST);
        d16      = (link_mode_select_r >= ddc_pkg::MODE_D16_FIRST) &&
                   (link_mode_select_r <= ddc_pkg::MODE_D16_LAST);
        no_flags = (link_mode_select_r == ddc_pkg::MODE_NO_FLAGS);
        byp      = !(d2 || d4 || d8 || d16);
    end

    // ------------------------------------------------------------------
    // Per-channel filter chain and formatter
    // ------------------------------------------------------------------
    for (genvar ch = 0; ch < 2; ch++) begin : chan
        logic           sv [ddc_pkg::NUM_SET];
        ddc_pkg::samp_t ss [ddc_pkg::NUM_SET];
        logic           ov [ddc_pkg::NUM_SET];
        ddc_pkg::samp_t os [ddc_pkg::NUM_SET];
        logic           fin_v;
        ddc_pkg::samp_t fin_s;
        logic [1:0]     flags_r;
        logic [1:0]     fl;
        logic           odd_r;

        for (genvar j = 0; j < ddc_pkg::NUM_SET; j++) begin : stg
            localparam bit LAST = (j == ddc_pkg::SET_55) || (j == ddc_pkg::SET_63);
            halfband_stage #(
                .SET (j),
                .OW  (LAST ? 15 : 16)
            ) u_stage (
                .clk_sys (clk_sys),
                .nrst    (nrst),
                .clr     (flush_r),
                .boost   (LAST ? boost_r : 1'b0),
                .in_v    (sv[j]),
                .in_s    (ss[j]),
                .out_v   (ov[j]),
                .out_s   (os[j])
            );
        end

        // Unused stages see no strobe and stay idle
        always_comb begin
            for (int j = 0; j < ddc_pkg::NUM_SET; j++) begin
                sv[j] = 1'b0;
                ss[j] = chan_in[ch];
            end
            sv[ddc_pkg::SET_7]  = in_valid & d16;
            sv[ddc_pkg::SET_11] = d16 ? ov[ddc_pkg::SET_7] : (in_valid & d8);
            ss[ddc_pkg::SET_11] = d16 ? os[ddc_pkg::SET_7] : chan_in[ch];
            sv[ddc_pkg::SET_15] = ov[ddc_pkg::SET_11];
            ss[ddc_pkg::SET_15] = os[ddc_pkg::SET_11];
            sv[ddc_pkg::SET_19] = in_valid & d4;
            sv[ddc_pkg::SET_63] = ov[ddc_pkg::SET_19] & quarter_rate_wide_passband_sel_r;
            ss[ddc_pkg::SET_63] = os[ddc_pkg::SET_19];
            if (d2) begin
                sv[ddc_pkg::SET_55] = in_valid;
            end else if (d4) begin
                sv[ddc_pkg::SET_55] = ov[ddc_pkg::SET_19] & ~quarter_rate_wide_passband_sel_r;
                ss[ddc_pkg::SET_55] = os[ddc_pkg::SET_19];
            end else begin
                sv[ddc_pkg::SET_55] = ov[ddc_pkg::SET_15] & (d8 | d16);
                ss[ddc_pkg::SET_55] = os[ddc_pkg::SET_15];
            end
        end

        always_comb begin
            if (d4 && quarter_rate_wide_passband_sel_r) begin
                fin_v = ov[ddc_pkg::SET_63];
                fin_s = os[ddc_pkg::SET_63];
            end else begin
                fin_v = ov[ddc_pkg::SET_55];
                fin_s = os[ddc_pkg::SET_55];
            end
        end

        assign emit[ch] = byp ? in_valid : fin_v;
        // A flag arriving in the emit cycle lands in that word; bypass and mode 9 drop the flags a word does not carry
        assign fl = flags_r | ovr_in[ch];

        always_ff @(posedge clk_sys) begin
            if (!nrst) begin
                flags_r      <= '0;
                odd_r        <= 1'b0;
                word_i_r[ch] <= '0;
                word_q_r[ch] <= '0;
                pin_r[ch]    <= '0;
            end else if (flush_r) begin
                flags_r      <= ovr_in[ch];
                odd_r        <= 1'b0;
                word_i_r[ch] <= '0;
                word_q_r[ch] <= '0;
                pin_r[ch]    <= '0;
            end else begin
                flags_r <= emit[ch] ? 2'b00 : fl;
                if (emit[ch]) begin
                    if (byp) begin
                        word_i_r[ch] <= {chan_in[ch].i[15:4], 4'h0};
                        word_q_r[ch] <= '0;
                    end else if (d2) begin
                        word_i_r[ch] <= {fin_s.i[14:0], odd_r ? fl[1] : fl[0]};
                        word_q_r[ch] <= '0;
                        odd_r        <= ~odd_r;
                    end else if (no_flags) begin
                        word_i_r[ch] <= {fin_s.i[14:3], 4'h0};
                        word_q_r[ch] <= {fin_s.q[14:3], 4'h0};
                    end else begin
                        word_i_r[ch] <= {fin_s.i[14:0], fl[0]};
                        word_q_r[ch] <= {fin_s.q[14:0], fl[1]};
                    end
                end
                if (!no_flags) begin
                    pin_r[ch] <= 2'b00;
                end else if (emit[ch]) begin
                    pin_r[ch] <= fl;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Output strobe and status
    // ------------------------------------------------------------------
    // Both channels share one input strobe, so channel A paces the pair
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            out_valid_r <= 1'b0;
            count_r     <= ddc_pkg::COUNT_RST;
        end else begin
            out_valid_r <= emit[0] & ~flush_r;
            if (emit[0] && !flush_r) begin
                count_r <= count_r + 16'h0001;
            end
        end
    end

    assign bus_rdata                   = rdata_r;
    assign out_valid                   = out_valid_r;
    assign word_i                      = word_i_r;
    assign word_q                      = word_q_r;
    assign chan_a_overrange_pin_first  = pin_r[0][0];
    assign chan_a_overrange_pin_second = pin_r[0][1];
    assign chan_b_overrange_pin_first  = pin_r[1][0];
    assign chan_b_overrange_pin_second = pin_r[1][1];

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    pins_idle_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        !no_flags |=> (pin_r[0] == 2'b00) && (pin_r[1] == 2'b00))
        else $error("Overrange pins driven outside mode 12");

    narrow_word_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (out_valid_r && $past(no_flags)) |-> (word_i_r[0][3:0] == 4'h0) && (word_q_r[1][3:0] == 4'h0))
        else $error("Mode 12 word carries low bits");

    real_q_zero_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (out_valid_r && $past(d2)) |-> (word_q_r[0] == 16'h0000))
        else $error("Real mode drove a quadrature word");

    real_flag_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (out_valid_r && $past(d2)) |->
        (word_i_r[0][0] == ($past(chan[0].odd_r) ? $past(chan[0].fl[1]) : $past(chan[0].fl[0]))))
        else $error("Real mode flag slot wrong");

    cplx_flag_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (out_valid_r && $past(!byp && !d2 && !no_flags)) |->
        (word_i_r[1][0] == $past(chan[1].fl[0])) && (word_q_r[1][0] == $past(chan[1].fl[1])))
        else $error("Complex flag slot wrong");

    quarter_gap_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (out_valid_r && d4) |=> !out_valid_r [*3])
        else $error("Decimate-by-4 outputs too close");

    sixteenth_gap_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (out_valid_r && d16) |=> !out_valid_r [*8])
        else $error("Decimate-by-16 outputs too close");

    bypass_pass_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (in_valid && byp && !flush_r) |=> out_valid_r)
        else $error("Bypass dropped a sample");

    rdata_idle_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        !$past(bus_rd) |-> (rdata_r == 16'h0000))
        else $error("Read data outside its cycle");

    mode_read_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (bus_rd && bus_addr == ddc_pkg::REG_MODE) |=> (rdata_r[4:0] == $past(link_mode_select_r)))
        else $error("Mode read back wrong");

endmodule

// file: ddc_pkg.sv
package ddc_pkg;

    // ------------------------------------------------------------------
    // Sample carrier
    // ------------------------------------------------------------------
    typedef struct packed {
        logic signed [15:0] i;
        logic signed [15:0] q;
    } samp_t;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [1:0]  REG_MODE       = 2'h0;
    localparam logic [1:0]  REG_CFG        = 2'h1;
    localparam logic [1:0]  REG_COUNT      = 2'h2;
    localparam int          CFG_WIDE_BIT   = 0;
    localparam int          CFG_BOOST_BIT  = 1;
    localparam logic [4:0]  MODE_RST       = 5'h00;
    localparam logic        WIDE_RST       = 1'h0;
    localparam logic        BOOST_RST      = 1'h0;
    localparam logic [15:0] COUNT_RST      = 16'h0000;

    // ------------------------------------------------------------------
    // Mode selector values
    // ------------------------------------------------------------------
    localparam logic [4:0]  MODE_D2        = 5'h09;
    localparam logic [4:0]  MODE_D4_FIRST  = 5'h0a;
    localparam logic [4:0]  MODE_NO_FLAGS  = 5'h0c;
    localparam logic [4:0]  MODE_D8_FIRST  = 5'h0d;
    localparam logic [4:0]  MODE_D16_FIRST = 5'h0f;
    localparam logic [4:0]  MODE_D16_LAST  = 5'h10;

    // ------------------------------------------------------------------
    // Half-band coefficient sets
    // ------------------------------------------------------------------
    localparam int SET_7   = 0;
    localparam int SET_11  = 1;
    localparam int SET_15  = 2;
    localparam int SET_19  = 3;
    localparam int SET_55  = 4;
    localparam int SET_63  = 5;
    localparam int NUM_SET = 6;
    localparam int NTAP_TBL  [NUM_SET] = '{7, 11, 15, 19, 55, 63};
    // Center tap is two to this power
    localparam int SHIFT_TBL [NUM_SET] = '{10, 13, 16, 15, 18, 14};
    localparam int C7  [2]  = '{-65, 577};
    localparam int C11 [3]  = '{109, -837, 4824};
    localparam int C15 [4]  = '{-327, 2231, -8881, 39742};
    localparam int C19 [5]  = '{56, -401, 1596, -4979, 20113};
    localparam int C55 [14] = '{-37, 118, -291, 612, -1159, 2031, -3356, 5308, -8140, 12284,
                                -18628, 29455, -53191, 166059};
    localparam int C63 [16] = '{-15, 23, -40, 64, -97, 142, -201, 279, -380, 513, -690, 939,
                                -1313, 1956, -3398, 10404};

    // Mirror about the center; odd offsets from the ends are zero
    function automatic logic signed [19:0] coef(input int set, input int k);
        int n;
        int h;
        int j;
        int v;
        n = NTAP_TBL[set];
        h = (n - 1) / 2;
        j = (k > h) ? (n - 1 - k) : k;
        v = 0;
        if (j == h) begin
            v = 1 << SHIFT_TBL[set];
        end else if ((j % 2) == 0) begin
            case (set)
                SET_7:   v = C7[j / 2];
                SET_11:  v = C11[j / 2];
                SET_15:  v = C15[j / 2];
                SET_19:  v = C19[j / 2];
                SET_55:  v = C55[j / 2];
                default: v = C63[j / 2];
            endcase
        end
        return 20'(v);
    endfunction

endpackage

// file: link_sink.sv
`timescale 1ns/1ps

module link_sink (
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic        out_valid,
    input  wire logic [15:0] word_i [2],
    output logic      [15:0] n_out,
    output logic      [15:0] last_i0,
    output logic      [15:0] prev_i0
);
    // ------------------------------------------------------------------
    // Sink
    // ------------------------------------------------------------------
    // Never stalls: the chain has no back-pressure, so a late sink loses data
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            n_out   <= 16'h0000;
            last_i0 <= 16'h0000;
            prev_i0 <= 16'h0000;
        end else if (out_valid) begin
            n_out   <= n_out + 16'h0001;
            last_i0 <= word_i[0];
            prev_i0 <= last_i0;
        end
    end
endmodule

// file: ddc_decim_format_tb.sv
`timescale 1ns/1ps

module ddc_decim_format_tb;
    logic           clk_sys;
    logic           nrst;
    logic [1:0]     bus_addr;
    logic [15:0]    bus_wdata;
    logic           bus_wr;
    logic           bus_rd;
    logic [15:0]    bus_rdata;
    logic           in_valid;
    ddc_pkg::samp_t chan_in [2];
    logic [1:0]     ovr_in  [2];
    logic           out_valid;
    logic [15:0]    word_i  [2];
    logic [15:0]    word_q  [2];
    wire  [3:0]     pins;
    logic [15:0]    n_out;
    logic [15:0]    last_i0;
    logic [15:0]    prev_i0;
    logic [15:0]    rd_v;
    int             fail_count;
    int             compares;
    int             seed;

    ddc_decim_format dut (.clk_sys(clk_sys), .nrst(nrst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .in_valid(in_valid), .chan_in(chan_in),
        .ovr_in(ovr_in), .out_valid(out_valid), .word_i(word_i), .word_q(word_q),
        .chan_a_overrange_pin_first(pins[3]), .chan_a_overrange_pin_second(pins[2]),
        .chan_b_overrange_pin_first(pins[1]), .chan_b_overrange_pin_second(pins[0]));
    link_sink sink (.clk_sys(clk_sys), .nrst(nrst), .out_valid(out_valid), .word_i(word_i),
        .n_out(n_out), .last_i0(last_i0), .prev_i0(prev_i0));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic summarize();
        $display("Totals: %0d compares, %0d mismatches", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Filter rounding is not exact, so data words get a small tolerance
    task automatic near(input string what, input int exp, input logic [14:0] got);
        int g;
        g = $signed(got);
        compares++;
        if ($isunknown(got) || g > exp + 16 || g < exp - 16) begin
            fail_count++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, exp, g);
        end
    endtask

    function automatic int e15(input logic [15:0] x, input bit b);
        int v;
        v = $signed(x) >>> 1;
        if (b) v = v * 2;
        return (v > 16383) ? 16383 : (v < -16384) ? -16384 : v;
    endfunction

    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk_sys);
        bus_wr <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [1:0] a);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk_sys);
        bus_rd <= 1'b0;
        @(posedge clk_sys);
        rd_v = bus_rdata;
    endtask

    task automatic run_mode(input logic [4:0] m, input logic [1:0] cfg, input logic [15:0] iv);
        logic [15:0] n0;
        int          d;
        int          k;
        bit          b;
        d = (m == ddc_pkg::MODE_D2) ? 2 : (m < ddc_pkg::MODE_D8_FIRST) ? 4 : (m < ddc_pkg::MODE_D16_FIRST) ? 8 : 16;
        b = cfg[ddc_pkg::CFG_BOOST_BIT];
        wr(ddc_pkg::REG_CFG, {14'h0000, cfg});
        wr(ddc_pkg::REG_MODE, {11'h000, m});
        n0 = n_out;
        chan_in[0] <= '{i: iv, q: 16'hf000};
        chan_in[1] <= '{i: 16'hf000, q: iv};
        k = 0;
        while (k < 32 * d) begin
            in_valid <= 1'($random(seed));
            @(posedge clk_sys);
            if (in_valid) k++;
        end
        in_valid <= 1'b0;
        repeat (300) @(posedge clk_sys);
        chk("output count", n0 + 16'h0020, n_out);
        rd(ddc_pkg::REG_COUNT);
        chk("count register", n_out, rd_v);
        near("data a i", e15(iv, b), word_i[0][15:1]);
        if (m == ddc_pkg::MODE_D2) begin
            chk("real q word", 16'h0000, word_q[0]);
            chk("even flag", 16'h0001, {15'h0000, prev_i0[0]});
            chk("odd flag", 16'h0000, {15'h0000, last_i0[0]});
        end else begin
            near("data a q", e15(16'hf000, b), word_q[0][15:1]);
            near("data b q", e15(iv, b), word_q[1][15:1]);
            if (m == ddc_pkg::MODE_NO_FLAGS) begin
                chk("low bits", 16'h0000, {12'h000, word_i[0][3:0]});
                chk("pins", 16'h0009, {12'h000, pins});
            end else begin
                chk("flags", 16'h0009, {12'h000, word_i[0][0], word_q[0][0], word_i[1][0], word_q[1][0]});
                chk("pins idle", 16'h0000, {12'h000, pins});
            end
        end
        $display("test mode %0d cfg %0d done", m, cfg);
    endtask

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (50000) @(posedge clk_sys);
        fail_count++;
        $display("Watchdog expired");
        summarize();
    end

    initial begin
        seed = 32'ha81c9e70;
        nrst = 1'b0;
        bus_addr = 2'h0;
        bus_wdata = 16'h0000;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        in_valid = 1'b0;
        chan_in[0] = '0;
        chan_in[1] = '0;
        ovr_in[0] = 2'h1;
        ovr_in[1] = 2'h2;
        repeat (12) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        for (int a = 0; a < 4; a++) begin
            rd(2'(a));
            chk("reset value", 16'h0000, rd_v);
        end
        wr(ddc_pkg::REG_COUNT, 16'h1234);
        wr(2'h3, 16'hffff);
        wr(ddc_pkg::REG_CFG, 16'h0003);
        rd(ddc_pkg::REG_COUNT);
        chk("count read only", 16'h0000, rd_v);
        rd(2'h3);
        chk("unmapped", 16'h0000, rd_v);
        rd(ddc_pkg::REG_CFG);
        chk("cfg", 16'h0003, rd_v);
        wr(ddc_pkg::REG_CFG, 16'h0000);
        $display("test registers done");
        for (int k = 0; k < 50; k++) begin
            chan_in[0] <= '{i: 16'($random(seed)), q: 16'($random(seed))};
            in_valid <= 1'b1;
            @(posedge clk_sys);
            in_valid <= 1'b0;
            #1;
            chk("bypass strobe", 16'h0001, {15'h0000, out_valid});
            chk("bypass word", {chan_in[0].i[15:4], 4'h0}, word_i[0]);
            @(posedge clk_sys);
        end
        $display("test bypass done");
        for (int m = 9; m <= 16; m++) begin
            run_mode(5'(m), 2'h0, {2'h0, 14'($random(seed))});
        end
        run_mode(ddc_pkg::MODE_D4_FIRST, 2'h1, 16'h2000);
        run_mode(ddc_pkg::MODE_D4_FIRST, 2'h2, 16'h2000);
        run_mode(ddc_pkg::MODE_D16_LAST, 2'h2, 16'h6000);
        summarize();
    end
endmodule
